// *** hdl/sysrst_regs.svh ***
// Source bit numbers, widths, reset values and timing counts of the system reset controller.
`ifndef SYSRST_REGS_SVH
`define SYSRST_REGS_SVH
`define SYSRST_CLK_HZ        25000000
`define SYSRST_TRST_US       50
`define SYSRST_TRST_CYC      ((`SYSRST_TRST_US * `SYSRST_CLK_HZ) / 1000000)
`define SYSRST_CNT_W         11
`define SYSRST_NSRC          8
`define SYSRST_PORT_W        8
`define SYSRST_PC_W          16
`define SYSRST_PC_RESET      16'h0000
`define SYSRST_LATCH_RESET   8'hFF
`define SYSRST_CAUSE_RESET   8'h01
`define SYSRST_SRC_POR       0
`define SYSRST_SRC_PIN       1
`define SYSRST_SRC_CMP       2
`define SYSRST_SRC_SW        3
`define SYSRST_SRC_SUPMON    4
`define SYSRST_SRC_WDT       5
`define SYSRST_SRC_MCD       6
`define SYSRST_SRC_FLASH     7
`endif

// *** hdl/sysrst_pkg.sv ***
// Types shared by the system reset controller.
`default_nettype none
package sysrst_pkg;
  typedef enum logic [1:0] {
    SYSRST_RUN   = 2'b00,
    SYSRST_HOLD  = 2'b01,
    SYSRST_DELAY = 2'b10
  } sysrst_state_t;

  typedef struct packed {
    logic       core_halt;
    logic       regs_reset;
    logic       regs_por_reset;
    logic       ram_write_block;
    logic       pc_clear;
    logic       clk_sel_internal;
    logic       wdt_force_enable;
    logic       irq_disable;
    logic       timer_disable;
    logic       port_force;
    logic       port_open_drain;
    logic       weak_pullup_en;
  } sysrst_ctl_t;
endpackage
`default_nettype wire

// *** hdl/sysrst_ctrl.sv ***
// System reset controller: gathers reset sources and sequences entry and exit.
//
// Overview of operation
// - Any active reset halts the core until exit.
// - Registers reset, except power-on-only bits on non-POR.
// - On-chip RAM contents are never disturbed by reset.
// - Port latches reset to one, open-drain drivers.
// - Weak pull-ups enabled during and after reset.
// - POR or supply monitor drives reset pin low.
// - Program counter cleared to zero on exit.
// - Clock selection returns to internal oscillator.
// - Watchdog enabled on leaving reset.
// - Interrupt enables cleared, timers disabled in reset.
// - Port pins forced to a defined state.
// - Eight sources each enter reset.
// - Non-POR release waits 50 us before execution.
`timescale 1ns/1ps
`default_nettype none
`include "sysrst_regs.svh"

module sysrst_ctrl
  import sysrst_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [`SYSRST_NSRC-1:0]    src_i,
  input  wire logic                       reset_pin_low_i,
  output logic                            reset_pin_low_o,
  output logic                            reset_pin_low_oe_o,
  output sysrst_ctl_t                     ctl_o,
  output logic [`SYSRST_PC_W-1:0]         pc_load_o,
  output logic [`SYSRST_PORT_W-1:0]       port_latch_o,
  output logic [`SYSRST_NSRC-1:0]         cause_o,
  output logic                            in_reset_o
);

  // The wait count must fit the counter width; a faster clock may need a wider counter.
  localparam logic [`SYSRST_CNT_W-1:0] DELAY_CYC = `SYSRST_CNT_W'(`SYSRST_TRST_CYC);

  // Sources other than POR come from other logic or a pin; sync all of them
  // so a sub-cycle glitch cannot half-enter reset. POR is also synced: the
  // controller's own rst_i covers the cycles before it settles.
  logic [`SYSRST_NSRC-1:0] src_s1_q;
  logic [`SYSRST_NSRC-1:0] src_s2_q;
  logic                    pin_s1_q;
  logic                    pin_s2_q;

  always_ff @(posedge clk_i) begin
    src_s1_q <= src_i;
    src_s2_q <= src_s1_q;
    pin_s1_q <= reset_pin_low_i;
    pin_s2_q <= pin_s1_q;
  end

  logic [`SYSRST_NSRC-1:0] src_live;
  logic                    any_src;
  logic                    drive_pin;
  logic [1:0]              own_hist_q;
  logic [1:0]              own_hist_d;
  logic                    own_mask;

  always_comb begin
    src_live = src_s2_q;
    // The pin is read back through its own input, so our own drive of it
    // would look like an external request; mask it while we drive it.
    src_live[`SYSRST_SRC_PIN] = src_s2_q[`SYSRST_SRC_PIN] | (pin_s2_q & ~own_mask);
    any_src = |src_live;
    drive_pin = src_live[`SYSRST_SRC_POR] | src_live[`SYSRST_SRC_SUPMON];
  end

  sysrst_state_t           state_q;
  sysrst_state_t           state_d;
  logic [`SYSRST_CNT_W-1:0] cnt_q;
  logic [`SYSRST_CNT_W-1:0] cnt_d;
  logic [`SYSRST_NSRC-1:0] cause_q;
  logic [`SYSRST_NSRC-1:0] cause_d;
  logic                    pin_q;
  logic                    pin_d;
  logic                    por_seen_q;
  logic                    por_seen_d;
  sysrst_ctl_t             ctl_q;
  sysrst_ctl_t             ctl_d;
  logic [`SYSRST_PC_W-1:0] pc_q;
  logic [`SYSRST_PC_W-1:0] pc_d;
  logic [`SYSRST_PORT_W-1:0] latch_q;
  logic [`SYSRST_PORT_W-1:0] latch_d;

  // Our own drive comes back through the pin synchroniser two cycles after
  // it stops, so the mask lasts two cycles longer than the drive; without
  // that, every reset that pulled the pin would be followed by a false one.
  always_comb begin
    own_hist_d = {own_hist_q[0], pin_q};
    own_mask   = pin_q | (|own_hist_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_hist_q <= 2'b11;
    end else begin
      own_hist_q <= own_hist_d;
    end
  end

  // RUN while no source is active, HOLD while any is, and DELAY for the wait
  // after a release that had no power-on part. Outputs are registered from the
  // next state so every control changes on the same edge.
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    cause_d    = cause_q;
    por_seen_d = por_seen_q;
    pin_d      = 1'b0;
    case (state_q)
      SYSRST_RUN: begin
        // A new reset reloads the cause register, so it names only the sources
        // of the latest reset; later sources are added while it lasts.
        if (any_src) begin
          state_d    = SYSRST_HOLD;
          cause_d    = src_live;
          por_seen_d = src_live[`SYSRST_SRC_POR];
          pin_d      = drive_pin;
        end
      end
      SYSRST_HOLD: begin
        cause_d    = cause_q | src_live;
        por_seen_d = por_seen_q | src_live[`SYSRST_SRC_POR];
        pin_d      = pin_q | drive_pin;
        if (!any_src) begin
          if (por_seen_q) begin
            // Power-on has its own analog delay before release.
            state_d = SYSRST_RUN;
          end else begin
            state_d = SYSRST_DELAY;
            cnt_d   = DELAY_CYC;
          end
        end
      end
      SYSRST_DELAY: begin
        pin_d = pin_q;
        // A source that returns during the wait sends the sequencer back to
        // HOLD; unless POR returned, the full wait starts again once every source is gone.
        if (any_src) begin
          state_d    = SYSRST_HOLD;
          cause_d    = cause_q | src_live;
          por_seen_d = por_seen_q | src_live[`SYSRST_SRC_POR];
          pin_d      = pin_q | drive_pin;
        end else if (cnt_q <= `SYSRST_CNT_W'(1)) begin
          state_d = SYSRST_RUN;
        end else begin
          cnt_d = cnt_q - `SYSRST_CNT_W'(1);
        end
      end
      default: begin
        state_d = SYSRST_HOLD;
      end
    endcase
    // The pin is let go on the same edge as the core, never a cycle later.
    if (state_d == SYSRST_RUN) begin
      pin_d = 1'b0;
    end
  end

  logic next_in_reset;

  always_comb begin
    next_in_reset = (state_d != SYSRST_RUN);
    ctl_d = '0;
    ctl_d.core_halt        = next_in_reset;
    ctl_d.regs_reset       = next_in_reset;
    // Power-on-only bits are reset only when a power-on source took part.
    ctl_d.regs_por_reset   = next_in_reset & por_seen_d;
    ctl_d.ram_write_block  = next_in_reset;
    ctl_d.pc_clear         = next_in_reset;
    ctl_d.clk_sel_internal = next_in_reset;
    ctl_d.wdt_force_enable = next_in_reset;
    ctl_d.irq_disable      = next_in_reset;
    ctl_d.timer_disable    = next_in_reset;
    ctl_d.port_force       = next_in_reset;
    ctl_d.port_open_drain  = next_in_reset;
    // Pull-ups stay on after release; firmware turns them off through its own register.
    ctl_d.weak_pullup_en   = 1'b1;
    pc_d    = `SYSRST_PC_RESET;
    latch_d = `SYSRST_LATCH_RESET;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= SYSRST_HOLD;
      cnt_q      <= '0;
      cause_q    <= `SYSRST_CAUSE_RESET;
      por_seen_q <= 1'b1;
      pin_q      <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cause_q    <= cause_d;
      por_seen_q <= por_seen_d;
      pin_q      <= pin_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q      <= '1;
      pc_q       <= `SYSRST_PC_RESET;
      latch_q    <= `SYSRST_LATCH_RESET;
    end else begin
      ctl_q      <= ctl_d;
      pc_q       <= pc_d;
      latch_q    <= latch_d;
    end
  end

  // Control outputs come from registers so the core never sees a glitch.
  assign reset_pin_low_o    = 1'b0;
  assign reset_pin_low_oe_o = pin_q;
  assign ctl_o              = ctl_q;
  assign pc_load_o          = pc_q;
  assign port_latch_o       = latch_q;
  assign cause_o            = cause_q;
  assign in_reset_o         = ctl_q.core_halt;

endmodule
`default_nettype wire

// *** verification/sysrst_ctrl_assertions.sv ***
// Concurrent checks on the ports of the system reset controller.
`timescale 1ns/1ps
`default_nettype none
`include "sysrst_regs.svh"
module sysrst_ctrl_assertions
  import sysrst_pkg::*;
(
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic [`SYSRST_NSRC-1:0]   src_i,
  input wire logic                      reset_pin_low_i,
  input wire logic                      reset_pin_low_o,
  input wire logic                      reset_pin_low_oe_o,
  input wire sysrst_ctl_t               ctl_o,
  input wire logic [`SYSRST_PC_W-1:0]   pc_load_o,
  input wire logic [`SYSRST_PORT_W-1:0] port_latch_o,
  input wire logic [`SYSRST_NSRC-1:0]   cause_o,
  input wire logic                      in_reset_o
);
  logic [10:0] quiet_q;
  logic        quiet_clr;
  // Counts quiet cycles of all sources; our own pin drive is not a source.
  // It saturates so a long idle run never wraps into the window.
  assign quiet_clr = rst_i || (|src_i) || (reset_pin_low_i && !reset_pin_low_oe_o);
  always_ff @(posedge clk_i) quiet_q <= quiet_clr ? 11'h000 : quiet_q + {10'h000, ~&quiet_q};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_exit;
    $fell(in_reset_o) ##0 !$past(ctl_o.regs_por_reset);
  endsequence
  a_source_enters: assert property ((|src_i) |-> ##3 in_reset_o) else $error("source did not hold reset");
  a_halt_irq_tmr: assert property (ctl_o.core_halt == in_reset_o && ctl_o.irq_disable == in_reset_o
    && ctl_o.timer_disable == in_reset_o) else $error("halt or irq or timer control wrong");
  a_regs_ram_hold: assert property (ctl_o.regs_reset == in_reset_o && ctl_o.ram_write_block == in_reset_o)
    else $error("register or ram control wrong");
  a_port_defined: assert property (port_latch_o == 8'hFF && (in_reset_o -> ctl_o.port_force && ctl_o.port_open_drain))
    else $error("port state wrong");
  a_pullup_kept: assert property (ctl_o.weak_pullup_en) else $error("pull-up dropped");
  a_pin_driven: assert property (reset_pin_low_oe_o |-> in_reset_o && !reset_pin_low_o) else $error("pin drive wrong");
  a_pin_by_cause: assert property (reset_pin_low_oe_o ==
    (in_reset_o && (cause_o[`SYSRST_SRC_POR] || cause_o[`SYSRST_SRC_SUPMON]))) else $error("pin drive not by cause");
  a_pc_exit_zero: assert property ($fell(in_reset_o) |-> pc_load_o == 16'h0000 && $past(ctl_o.pc_clear))
    else $error("pc not cleared at exit");
  a_exit_clk_wdt: assert property ($fell(in_reset_o) |-> $past(ctl_o.clk_sel_internal) && $past(ctl_o.wdt_force_enable))
    else $error("clock or watchdog not forced at exit");
  a_exit_delay: assert property (s_exit |-> quiet_q >= 11'h4E2 && quiet_q <= 11'h4EE) else $error("exit delay wrong");
endmodule
bind sysrst_ctrl sysrst_ctrl_assertions u_chk (.clk_i, .rst_i, .src_i, .reset_pin_low_i, .reset_pin_low_o,
  .reset_pin_low_oe_o, .ctl_o, .pc_load_o, .port_latch_o, .cause_o, .in_reset_o);
`default_nettype wire

// *** verification/sysrst_pin_model.sv ***
// Reset pin on the board: pull-up, the device driver and an outside push button.
`timescale 1ns/1ps
`default_nettype none
module sysrst_pin_model (
  input  wire logic oe_i,
  input  wire logic drv_low_i,
  input  wire logic push_i,
  output logic      pin_low_o
);
  // The pull-up keeps the pin high whenever neither party pulls it down.
  assign pin_low_o = (oe_i & ~drv_low_i) | push_i;
endmodule
`default_nettype wire

// *** verification/sysrst_ctrl_bench.sv ***
// Self-checking bench for the system reset controller.
`timescale 1ns/1ps
`default_nettype none
`include "sysrst_regs.svh"
module sysrst_ctrl_bench;
  import sysrst_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, push = 1'b0, pin_low, oe, drv, in_rst;
  logic [7:0]  src = 8'h00, latch, cause;
  logic [15:0] pc;
  sysrst_ctl_t ctl;
  int          miscompares = 0, n_tests = 0;
  sysrst_ctrl dut (.clk_i, .rst_i, .src_i(src), .reset_pin_low_i(pin_low), .reset_pin_low_o(drv), .reset_pin_low_oe_o(oe),
    .ctl_o(ctl), .pc_load_o(pc), .port_latch_o(latch), .cause_o(cause), .in_reset_o(in_rst));
  sysrst_pin_model pin (.oe_i(oe), .drv_low_i(drv), .push_i(push), .pin_low_o(pin_low));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_exit(output int n);
    n = 0;
    while (in_rst === 1'b1 && n < 3000) begin @(posedge clk_i); #1; n++; end
  endtask
  // Source 1 is raised through the pin itself, so the pin input path is exercised.
  task automatic t_source(input int k);
    int n;
    @(posedge clk_i);
    if (k == 1) push <= 1'b1; else src <= 8'h01 << k;
    repeat (6) @(posedge clk_i);
    #1;
    chk("halt", in_rst, 1'b1);
    chk("cause", cause, 16'h0001 << k);
    chk("pin_oe", oe, (k == 0 || k == 4));
    chk("ctl_in", ctl, (k == 0) ? 16'h0FFF : 16'h0DFF);
    @(posedge clk_i);
    push <= 1'b0;
    src <= 8'h00;
    wait_exit(n);
    chk("delay", (k == 0) ? n < 10 : n > 1249 && n < 1264, 1'b1);
    chk("pc", pc, 16'h0000);
    chk("latch", latch, 16'h00FF);
    chk("ctl_out", ctl, 16'h0001);
    chk("pin_rel", oe, 1'b0);
  endtask
  task automatic t_overlap();
    int n;
    @(posedge clk_i);
    src <= 8'h28;
    repeat (8) @(posedge clk_i);
    src <= 8'h20;
    repeat (1400) @(posedge clk_i);
    #1;
    chk("held", in_rst, 1'b1);
    @(posedge clk_i);
    src <= 8'h00;
    repeat (600) @(posedge clk_i);
    src <= 8'h04;
    repeat (4) @(posedge clk_i);
    src <= 8'h00;
    wait_exit(n);
    chk("restart", n > 1249 && n < 1264, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int k = 0; k < 8; k++) t_source(k);
    t_overlap();
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
